// file: rtl/dop_pkg.sv
// Notes on behaviour
// - each port eight pins, per-bit control
// - direction 0 output, 1 input, resets 0
// - direction chosen per pin independently
// - output code 00 leaves pin undriven
// - output code 01 is P-channel open drain
// - output code 10 is N-channel open drain
// - output code 11 drives both levels
// - input code 01 enables pull-down
// - input code 10 enables pull-up
// - input codes 00, 11 float, no pull
// - reset gives high-impedance output everywhere
// - output pin shows data bit per drive
// - output pins read back stored data
// - input pins read the sensed level
// - control pair as bytes or word
// - data and direction byte-wide, reset zero
// - segment select overrides port use
package dop_pkg;
  // ----------------------------------------
  // register byte addresses
  // ----------------------------------------
  localparam logic [15:0] AddrEData = 16'hF270;
  localparam logic [15:0] AddrEDir = 16'hF271;
  localparam logic [15:0] AddrECon0 = 16'hF272;
  localparam logic [15:0] AddrECon1 = 16'hF273;
  localparam logic [15:0] AddrFData = 16'hF278;
  localparam logic [15:0] AddrFDir = 16'hF279;
  localparam logic [15:0] AddrFCon0 = 16'hF27A;
  localparam logic [15:0] AddrFCon1 = 16'hF27B;
  // ----------------------------------------
  // reset values and pin-state codes
  // ----------------------------------------
  localparam logic [7:0] ResetByte = 8'h00;
  localparam logic [1:0] CodeHiZ = 2'h0;
  localparam logic [1:0] CodePOpen = 2'h1;
  localparam logic [1:0] CodeNOpen = 2'h2;
  localparam logic [1:0] CodeCmos = 2'h3;
  localparam int PortWidth = 8;
endpackage

// file: rtl/dop_port.sv
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
// ----------------------------------------
// dual eight-bit general-purpose port
// ----------------------------------------
module dop_port #(
  parameter int Width = dop_pkg::PortWidth
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [15:0] busAddr,
  input wire logic [15:0] busWdata,
  input wire logic busWordWr,
  input wire logic busWr,
  input wire logic busRd,
  output logic [15:0] busRdata,
  input wire logic [Width-1:0] ePinIn,
  output logic [Width-1:0] ePinOut,
  output logic [Width-1:0] ePinOe,
  output logic [Width-1:0] ePullUp,
  output logic [Width-1:0] ePullDown,
  input wire logic [Width-1:0] segmentSelectThree,
  input wire logic [Width-1:0] fPinIn,
  output logic [Width-1:0] fPinOut,
  output logic [Width-1:0] fPinOe,
  output logic [Width-1:0] fPullUp,
  output logic [Width-1:0] fPullDown,
  input wire logic [Width-1:0] segmentSelectFour
);
  // the register map is eight bits per pin register
  // a wider port would need a second byte lane for every register
  if (Width != 8) begin : g_width_check
    $error("dop_port supports width 8 only");
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] eData_q, eDir_q, eCon0_q, eCon1_q; // port e
  logic [7:0] fData_q, fDir_q, fCon0_q, fCon1_q; // port f
  logic [7:0] eSync1_q, eSync2_q; // pin synchroniser e
  logic [7:0] fSync1_q, fSync2_q; // pin synchroniser f
  logic [15:0] rdata_q; // read data, valid one cycle after strobe

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  // word access hits the low address only and fills both control bytes
  // a word flag on any other address is taken as a plain byte access
  // data register strobes
  wire wEData = busWr & (busAddr == dop_pkg::AddrEData);
  // direction register strobes
  wire wEDir = busWr & (busAddr == dop_pkg::AddrEDir);
  // control 0 is written by a byte or a word at its own address
  wire wECon0 = busWr & (busAddr == dop_pkg::AddrECon0);
  // control 1 by a byte at its own address or a word at control 0
  wire wECon1 = busWr & ((busAddr == dop_pkg::AddrECon1)
                         | (busAddr == dop_pkg::AddrECon0) & busWordWr);
  wire wFData = busWr & (busAddr == dop_pkg::AddrFData);
  wire wFDir = busWr & (busAddr == dop_pkg::AddrFDir);
  wire wFCon0 = busWr & (busAddr == dop_pkg::AddrFCon0);
  wire wFCon1 = busWr & ((busAddr == dop_pkg::AddrFCon1)
                         | (busAddr == dop_pkg::AddrFCon0) & busWordWr);
  // control 0 sits at an even address, so bit 0 low marks the word's base
  wire con1HiSel = busWordWr & ~busAddr[0];
  // high byte of a word write goes to control register 1
  wire [7:0] con1Wdata = con1HiSel ? busWdata[15:8] : busWdata[7:0];

  // ----------------------------------------
  // register file, all zero after reset
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      eData_q <= dop_pkg::ResetByte;
      eDir_q <= dop_pkg::ResetByte;
      eCon0_q <= dop_pkg::ResetByte;
      eCon1_q <= dop_pkg::ResetByte;
      fData_q <= dop_pkg::ResetByte;
      fDir_q <= dop_pkg::ResetByte;
      fCon0_q <= dop_pkg::ResetByte;
      fCon1_q <= dop_pkg::ResetByte;
    end else begin
      if (wEData) eData_q <= busWdata[7:0];
      if (wEDir) eDir_q <= busWdata[7:0];
      if (wECon0) eCon0_q <= busWdata[7:0];
      if (wECon1) eCon1_q <= con1Wdata;
      if (wFData) fData_q <= busWdata[7:0];
      if (wFDir) fDir_q <= busWdata[7:0];
      if (wFCon0) fCon0_q <= busWdata[7:0];
      if (wFCon1) fCon1_q <= con1Wdata;
    end
  end

  // ----------------------------------------
  // pin synchronisers, first stage read only by second
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      eSync1_q <= dop_pkg::ResetByte;
      eSync2_q <= dop_pkg::ResetByte;
      fSync1_q <= dop_pkg::ResetByte;
      fSync2_q <= dop_pkg::ResetByte;
    end else begin
      eSync1_q <= ePinIn;
      eSync2_q <= eSync1_q;
      fSync1_q <= fPinIn;
      fSync2_q <= fSync1_q;
    end
  end

  // ----------------------------------------
  // per-pin drive decode
  // ----------------------------------------
  logic [7:0] eDrv, eLvl, ePu, ePd, fDrv, fLvl, fPu, fPd;
  genvar i;
  generate
    // one slice per pin, every pin set up on its own
    for (i = 0; i < Width; i++) begin : g_pin
      // code bit 0 from control 0, bit 1 from control 1
      wire [1:0] eCode = {eCon1_q[i], eCon0_q[i]};
      wire [1:0] fCode = {fCon1_q[i], fCon0_q[i]};
      wire eOut = ~eDir_q[i] & ~segmentSelectThree[i];
      wire fOut = ~fDir_q[i] & ~segmentSelectFour[i];
      wire eIn = eDir_q[i] & ~segmentSelectThree[i];
      wire fIn = fDir_q[i] & ~segmentSelectFour[i];
      // drive enable: cmos always, p open drain on 1, n open drain on 0
      assign eDrv[i] = eOut & ((eCode == dop_pkg::CodeCmos)
                       | (eCode == dop_pkg::CodePOpen) & eData_q[i]
                       | (eCode == dop_pkg::CodeNOpen) & ~eData_q[i]);
      assign fDrv[i] = fOut & ((fCode == dop_pkg::CodeCmos)
                       | (fCode == dop_pkg::CodePOpen) & fData_q[i]
                       | (fCode == dop_pkg::CodeNOpen) & ~fData_q[i]);
      assign eLvl[i] = eData_q[i];
      assign fLvl[i] = fData_q[i];
      // pulls only in input mode; codes 00 and 11 float
      assign ePd[i] = eIn & (eCode == dop_pkg::CodePOpen);
      assign ePu[i] = eIn & (eCode == dop_pkg::CodeNOpen);
      assign fPd[i] = fIn & (fCode == dop_pkg::CodePOpen);
      assign fPu[i] = fIn & (fCode == dop_pkg::CodeNOpen);
    end
  endgenerate

  // ----------------------------------------
  // pad controls, straight from the decode
  // ----------------------------------------
  // enables are combinational from registers, so they move right after a write
  assign ePinOe = eDrv;
  assign ePinOut = eLvl;
  assign ePullUp = ePu;
  assign ePullDown = ePd;
  assign fPinOe = fDrv;
  assign fPinOut = fLvl;
  assign fPullUp = fPu;
  assign fPullDown = fPd;

  // ----------------------------------------
  // read path: output pins give stored bit, input pins the sensed level
  // ----------------------------------------
  wire [7:0] eRead = (eData_q & ~eDir_q) | (eSync2_q & eDir_q);
  wire [7:0] fRead = (fData_q & ~fDir_q) | (fSync2_q & fDir_q);
  wire [15:0] rdMux =
      (busAddr == dop_pkg::AddrEData) ? {8'h00, eRead} :
      (busAddr == dop_pkg::AddrEDir) ? {8'h00, eDir_q} :
      (busAddr == dop_pkg::AddrECon0) ? {eCon1_q, eCon0_q} :
      (busAddr == dop_pkg::AddrECon1) ? {8'h00, eCon1_q} :
      (busAddr == dop_pkg::AddrFData) ? {8'h00, fRead} :
      (busAddr == dop_pkg::AddrFDir) ? {8'h00, fDir_q} :
      (busAddr == dop_pkg::AddrFCon0) ? {fCon1_q, fCon0_q} :
      (busAddr == dop_pkg::AddrFCon1) ? {8'h00, fCon1_q} : 16'h0000;

  // read data held only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!rstn) rdata_q <= 16'h0000;
    else if (busRd) rdata_q <= rdMux;
    else rdata_q <= 16'h0000;
  end
  assign busRdata = rdata_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  reset_hiz_a: assert property (@(posedge ref_clk) $fell(rstn) |=> (ePinOe == 8'h00 && fPinOe == 8'h00))
    else $error("pins driven after reset");
  input_nodrive_a: assert property (@(posedge ref_clk) disable iff (!rstn) (ePinOe & eDir_q) == 8'h00)
    else $error("input pin driven");
  cmos_drive_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (eCon0_q == 8'hFF && eCon1_q == 8'hFF && eDir_q == 8'h00 && segmentSelectThree == 8'h00)
      |-> ePinOe == 8'hFF) else $error("cmos pins not driven");
  hiz_code_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      ((fPinOe & ~(fCon0_q | fCon1_q)) == 8'h00)) else $error("code 00 pin driven");
  pull_input_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      ((ePullUp | ePullDown) & ~eDir_q) == 8'h00 && (ePullUp & ePullDown) == 8'h00)
    else $error("pull on output pin");
  segment_off_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (fPinOe & segmentSelectFour) == 8'h00) else $error("segment pin driven");
  word_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (busWr && busWordWr && busAddr == dop_pkg::AddrECon0) |=> eCon1_q == $past(busWdata[15:8]))
    else $error("word write missed high byte");
  dir_read_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (busRd && busAddr == dop_pkg::AddrFDir) |=> busRdata == {8'h00, $past(fDir_q)})
    else $error("direction readback wrong");
  data_read_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (busRd && busAddr == dop_pkg::AddrEData && eDir_q == 8'h00) |=> busRdata[7:0] == $past(eData_q))
    else $error("output data readback wrong");

  // ----------------------------------------
  // drive check mirrors for the other port, per-bit drive checks on both ports
  // ----------------------------------------
  // an input pin of port f never drives
  f_input_nodrive_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (fPinOe & fDir_q) == 8'h00)
    else $error("port f input pin driven");

  // code 00 on port e leaves the pin undriven
  e_hiz_code_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (ePinOe & ~(eCon0_q | eCon1_q)) == 8'h00)
    else $error("port e code 00 pin driven");

  // every cmos output pin of port e drives, bit by bit
  e_cmos_bits_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      ((eCon0_q & eCon1_q & ~eDir_q & ~segmentSelectThree) & ~ePinOe) == 8'h00)
    else $error("port e cmos pin not driven");

  // every cmos output pin of port f drives, bit by bit
  f_cmos_bits_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      ((fCon0_q & fCon1_q & ~fDir_q & ~segmentSelectFour) & ~fPinOe) == 8'h00)
    else $error("port f cmos pin not driven");

  // p open drain on port e drives exactly where the data bit is one
  e_popen_high_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      ((eCon0_q & ~eCon1_q & ~eDir_q & ~segmentSelectThree) & (ePinOe ^ eData_q)) == 8'h00)
    else $error("port e p open drain wrong");

  // p open drain on port f drives exactly where the data bit is one
  f_popen_high_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      ((fCon0_q & ~fCon1_q & ~fDir_q & ~segmentSelectFour) & (fPinOe ^ fData_q)) == 8'h00)
    else $error("port f p open drain wrong");

  // n open drain on port e drives exactly where the data bit is zero
  e_nopen_low_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      ((~eCon0_q & eCon1_q & ~eDir_q & ~segmentSelectThree) & (ePinOe ^ ~eData_q)) == 8'h00)
    else $error("port e n open drain wrong");

  // n open drain on port f drives exactly where the data bit is zero
  f_nopen_low_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      ((~fCon0_q & fCon1_q & ~fDir_q & ~segmentSelectFour) & (fPinOe ^ ~fData_q)) == 8'h00)
    else $error("port f n open drain wrong");

  // the level offered to the pad is always the stored data
  e_level_data_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      ePinOut == eData_q)
    else $error("port e pin level wrong");

  // same for port f
  f_level_data_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      fPinOut == fData_q)
    else $error("port f pin level wrong");

  // ----------------------------------------
  // pull resistor checks
  // ----------------------------------------
  // pulls of port f only on input pins and never both at once
  f_pull_input_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      ((fPullUp | fPullDown) & ~fDir_q) == 8'h00 && (fPullUp & fPullDown) == 8'h00)
    else $error("port f pull on output pin");

  // pull-down of port e follows code 01 on input pins exactly
  e_pulldown_code_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      ePullDown == (eDir_q & eCon0_q & ~eCon1_q & ~segmentSelectThree))
    else $error("port e pull-down wrong");

  // pull-down of port f follows code 01 on input pins exactly
  f_pulldown_code_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      fPullDown == (fDir_q & fCon0_q & ~fCon1_q & ~segmentSelectFour))
    else $error("port f pull-down wrong");

  // pull-up of port e follows code 10 on input pins exactly
  e_pullup_code_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      ePullUp == (eDir_q & ~eCon0_q & eCon1_q & ~segmentSelectThree))
    else $error("port e pull-up wrong");

  // pull-up of port f follows code 10 on input pins exactly
  f_pullup_code_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      fPullUp == (fDir_q & ~fCon0_q & fCon1_q & ~segmentSelectFour))
    else $error("port f pull-up wrong");

  // codes 00 and 11 on an input pin of port e: no pull, no drive
  e_float_nopull_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (~(eCon0_q ^ eCon1_q) & eDir_q & (ePullUp | ePullDown | ePinOe)) == 8'h00)
    else $error("port e floating input not floating");

  // codes 00 and 11 on an input pin of port f: no pull, no drive
  f_float_nopull_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (~(fCon0_q ^ fCon1_q) & fDir_q & (fPullUp | fPullDown | fPinOe)) == 8'h00)
    else $error("port f floating input not floating");

  // ----------------------------------------
  // segment hand-over
  // ----------------------------------------
  // a pin of port e given to the display gets no drive and no pull
  e_segment_off_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      ((ePinOe | ePullUp | ePullDown) & segmentSelectThree) == 8'h00)
    else $error("port e segment pin used");

  // a pin of port f given to the display gets no pull
  f_segment_pulls_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      ((fPullUp | fPullDown) & segmentSelectFour) == 8'h00)
    else $error("port f segment pin pulled");

  // ----------------------------------------
  // register access checks
  // ----------------------------------------
  // a word write to port f control fills both bytes
  f_word_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (busWr && busWordWr && busAddr == dop_pkg::AddrFCon0)
      |=> fCon1_q == $past(busWdata[15:8]) && fCon0_q == $past(busWdata[7:0]))
    else $error("port f word write wrong");

  // a read at port e control 0 returns the pair
  e_word_read_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (busRd && busAddr == dop_pkg::AddrECon0) |=> busRdata == {$past(eCon1_q), $past(eCon0_q)})
    else $error("port e control pair readback wrong");

  // a byte write to control 1 of port e leaves control 0 alone
  e_con1_byte_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (busWr && busAddr == dop_pkg::AddrECon1) |=> eCon1_q == $past(busWdata[7:0]) && $stable(eCon0_q))
    else $error("port e control 1 byte write wrong");

  // a byte write to control 1 of port f leaves control 0 alone
  f_con1_byte_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (busWr && busAddr == dop_pkg::AddrFCon1) |=> fCon1_q == $past(busWdata[7:0]) && $stable(fCon0_q))
    else $error("port f control 1 byte write wrong");

  // direction bits of port e take the written byte
  e_dir_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (busWr && busAddr == dop_pkg::AddrEDir) |=> eDir_q == $past(busWdata[7:0]))
    else $error("port e direction write wrong");

  // direction bits of port f take the written byte
  f_dir_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (busWr && busAddr == dop_pkg::AddrFDir) |=> fDir_q == $past(busWdata[7:0]))
    else $error("port f direction write wrong");

  // data of port e takes the written byte
  e_data_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (busWr && busAddr == dop_pkg::AddrEData) |=> eData_q == $past(busWdata[7:0]))
    else $error("port e data write wrong");

  // data of port f takes the written byte
  f_data_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (busWr && busAddr == dop_pkg::AddrFData) |=> fData_q == $past(busWdata[7:0]))
    else $error("port f data write wrong");

  // all-output port f reads back its stored data
  f_data_read_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (busRd && busAddr == dop_pkg::AddrFData && fDir_q == 8'h00) |=> busRdata[7:0] == $past(fData_q))
    else $error("port f output readback wrong");

  // all-input port e reads the synchronised pin level
  e_input_read_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (busRd && busAddr == dop_pkg::AddrEData && eDir_q == 8'hFF) |=> busRdata[7:0] == $past(eSync2_q))
    else $error("port e input readback wrong");

  // all-input port f reads the synchronised pin level
  f_input_read_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (busRd && busAddr == dop_pkg::AddrFData && fDir_q == 8'hFF) |=> busRdata[7:0] == $past(fSync2_q))
    else $error("port f input readback wrong");

  // read data stand one cycle only, zero otherwise
  read_idle_zero_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      !busRd |=> busRdata == 16'h0000)
    else $error("read data outside its cycle");

  // reset clears every mode register, whatever came before
  reset_regs_a: assert property (@(posedge ref_clk)
      !rstn |=> (eDir_q | eCon0_q | eCon1_q | fDir_q | fCon0_q | fCon1_q) == 8'h00)
    else $error("mode registers not cleared by reset");
endmodule

// file: sim/dop_pins.sv
`timescale 1ns/1ps
// ----------------------------------------
// board side of one eight-pin port
// ----------------------------------------
module dop_pins (
  input wire logic ref_clk,
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOe,
  input wire logic [7:0] pullUp,
  input wire logic [7:0] pullDown,
  input wire logic [7:0] extEn,
  input wire logic [7:0] extVal,
  output logic [7:0] pinLevel
);
  // last resolved level, so a floating pin never shows a stale value
  logic [7:0] lastQ = 8'h00;
  // device drive wins, then board drive, then pulls; a float flips
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pinOe[i]) pinLevel[i] = pinOut[i];
      else if (extEn[i]) pinLevel[i] = extVal[i];
      else if (pullUp[i]) pinLevel[i] = 1'b1;
      else if (pullDown[i]) pinLevel[i] = 1'b0;
      else pinLevel[i] = ~lastQ[i];
    end
  end
  // remember the level for the float pattern
  always_ff @(posedge ref_clk) lastQ <= pinLevel;
endmodule

// file: sim/dual_octal_io_port_test.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module dual_octal_io_port_test;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] busAddr = 16'h0000;
  logic [15:0] busWdata = 16'h0000;
  logic busWordWr = 1'b0;
  logic busWr = 1'b0;
  logic busRd = 1'b0;
  logic [7:0] segSel [2] = '{8'h00, 8'h00};
  logic [7:0] extEn [2] = '{8'h00, 8'h00};
  logic [7:0] extVal [2] = '{8'h00, 8'h00};
  logic [15:0] b;
  wire [15:0] busRdata;
  wire [7:0] pinIn [2];
  wire [7:0] pinOut [2];
  wire [7:0] pinOe [2];
  wire [7:0] pullUp [2];
  wire [7:0] pullDown [2];
  int n_mismatch = 0;
  int compares = 0;
  // expected drive and pulls per pin-state code, data pattern a5
  logic [7:0] oeTab [4] = '{8'h00, 8'hA5, 8'h5A, 8'hFF};
  logic [7:0] puTab [4] = '{8'h00, 8'h00, 8'hFF, 8'h00};
  logic [7:0] pdTab [4] = '{8'h00, 8'hFF, 8'h00, 8'h00};
  initial forever #50 ref_clk = ~ref_clk;
  dop_port DUT (.ref_clk(ref_clk), .rstn(rstn), .busAddr(busAddr), .busWdata(busWdata),
    .busWordWr(busWordWr), .busWr(busWr), .busRd(busRd), .busRdata(busRdata),
    .ePinIn(pinIn[0]), .ePinOut(pinOut[0]), .ePinOe(pinOe[0]), .ePullUp(pullUp[0]),
    .ePullDown(pullDown[0]), .segmentSelectThree(segSel[0]), .fPinIn(pinIn[1]),
    .fPinOut(pinOut[1]), .fPinOe(pinOe[1]), .fPullUp(pullUp[1]), .fPullDown(pullDown[1]),
    .segmentSelectFour(segSel[1]));
  // one board model per port
  for (genvar p = 0; p < 2; p++) begin : g_pin
    dop_pins u_pins (.ref_clk(ref_clk), .pinOut(pinOut[p]), .pinOe(pinOe[p]), .pullUp(pullUp[p]),
      .pullDown(pullDown[p]), .extEn(extEn[p]), .extVal(extVal[p]), .pinLevel(pinIn[p]));
  end
  // ----------------------------------------
  // bus tasks; each leaves a gap edge so strobes never double-assign
  // ----------------------------------------
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic w);
    @(posedge ref_clk);
    busAddr <= a;
    busWdata <= d;
    busWordWr <= w;
    busWr <= 1'b1;
    @(posedge ref_clk);
    busWr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a, input logic w, input logic [15:0] ex, input string nm);
    @(posedge ref_clk);
    busAddr <= a;
    busWordWr <= w;
    busRd <= 1'b1;
    @(posedge ref_clk);
    busRd <= 1'b0;
    #1;
    `CHK(nm, ex, busRdata)
  endtask
  task automatic pins(input int p, input logic [7:0] oe, input logic [7:0] pu, input logic [7:0] pd);
    `CHK("pinOe", oe, pinOe[p])
    `CHK("pullUp", pu, pullUp[p])
    `CHK("pullDown", pd, pullDown[p])
  endtask
  task automatic finish_test;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard: well past the whole sequence
  initial begin
    #2000000;
    n_mismatch++;
    finish_test();
  end
  // ----------------------------------------
  // main sequence, same checks on each port in turn, then unmapped and port f reset checks
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      b = p ? dop_pkg::AddrFData : dop_pkg::AddrEData;
      pins(p, 8'h00, 8'h00, 8'h00);
      for (int k = 0; k < 4; k++) rd(b + k[15:0], 1'b0, 16'h0000, "resetVal");
      wr(b, 16'h00A5, 1'b0);
      `CHK("pinOut", 8'hA5, pinOut[p])
      // every code, first as output then as input
      for (int c = 0; c < 4; c++) begin
        wr(b + 16'h0002, {8'h00, {8{c[0]}}}, 1'b0);
        wr(b + 16'h0003, {8'h00, {8{c[1]}}}, 1'b0);
        pins(p, oeTab[c], 8'h00, 8'h00);
        wr(b + 16'h0001, 16'h00FF, 1'b0);
        pins(p, 8'h00, puTab[c], pdTab[c]);
        wr(b + 16'h0001, 16'h0000, 1'b0);
      end
      // word write: high nibble cmos, low nibble code 01
      wr(b + 16'h0002, 16'hF0FF, 1'b1);
      rd(b + 16'h0003, 1'b0, 16'h00F0, "ctl1");
      rd(b + 16'h0002, 1'b1, 16'hF0FF, "ctlWord");
      wr(b + 16'h0001, 16'h000F, 1'b0);
      pins(p, 8'hF0, 8'h00, 8'h0F);
      extVal[p] <= 8'h3C;
      extEn[p] <= 8'hFF;
      repeat (3) @(posedge ref_clk);
      rd(b, 1'b0, 16'h00AC, "dataMixed");
      segSel[p] <= 8'hFF;
      #10;
      pins(p, 8'h00, 8'h00, 8'h00);
      segSel[p] <= 8'h00;
      extEn[p] <= 8'h00;
    end
    // unmapped place: write ignored, reads zero
    wr(16'hF274, 16'h00FF, 1'b0);
    rd(16'hF274, 1'b0, 16'h0000, "unmapped");
    // second reset in mid-run clears the control pair
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(dop_pkg::AddrFCon0, 1'b1, 16'h0000, "ctlAfterReset");
    pins(1, 8'h00, 8'h00, 8'h00);
    finish_test();
  end
endmodule
